// ---- common/psefe_pkg.sv ----
// Purpose: shared constants and types of the fault and supply event registers
// Assumes: 25 MHz system clock, AXI4-Lite register access
// Notes:   register byte address is four times the register index
package psefe_pkg;
  // ----------------------------------------------------------------
  // clock and bus
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ  = 25;
  localparam int          AXI_AW   = 8;
  localparam int          NPORT    = 4;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
  localparam logic [1:0]  ADDR_LSB = 2'h2;
  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [5:0]  IDX_SL     = 6'h08;
  localparam logic [5:0]  IDX_SL_COR = 6'h09;
  localparam logic [5:0]  IDX_SU     = 6'h0a;
  localparam logic [5:0]  IDX_SU_COR = 6'h0b;
  localparam logic [5:0]  IDX_LIM_AB = 6'h1e;
  localparam logic [5:0]  IDX_LIM_CD = 6'h1f;
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int          LIM_LSB    = 4;
  localparam int          LIM_FW     = 4;
  localparam int          SU_NEG_BIT = 4;
  localparam int          SU_LOG_BIT = 5;
  localparam int          SU_TMP_BIT = 7;
  localparam logic [7:0]  SU_RSV     = 8'h4f;
  localparam logic [7:0]  EV_RST     = 8'h00;
  localparam logic [7:0]  LIM_RST    = 8'h00;

  typedef struct packed {
    logic [NPORT-1:0] startup_phase;
    logic [NPORT-1:0] over_startup;
    logic [NPORT-1:0] over_limit;
    logic             neg_supply_low_flag;
    logic             logic_supply_low_flag;
    logic             over_temp;
  } psefe_fault_in_type;
endpackage

// ---- core/psefe_port_timer.sv ----
// Purpose: per-port start-up and current-limit overcurrent timers
// Assumes: inputs already synchronised to clk
// Notes:   each fault fires once per continuous overcurrent episode
`timescale 1ns/1ps
module psefe_port_timer
  import psefe_pkg::*;
#(
  parameter int CNT_W = 24
)(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             start_phase,
  input  wire logic             over_start,
  input  wire logic             over_lim,
  input  wire logic [CNT_W-1:0] start_cycles,
  input  wire logic [CNT_W-1:0] lim_cycles,
  output logic                  start_flt,
  output logic                  lim_flt
);
  logic [CNT_W-1:0] st_cnt_q, st_cnt_d, lm_cnt_q, lm_cnt_d;
  logic             st_run, lm_run;

  // ----------------------------------------------------------------
  // counters saturate one past the allowance so the fault fires once
  // ----------------------------------------------------------------
  always_comb begin
    st_run    = start_phase & over_start;
    lm_run    = ~start_phase & over_lim;
    st_cnt_d  = st_cnt_q;
    lm_cnt_d  = lm_cnt_q;
    if (!st_run) begin
      st_cnt_d = '0;
    end else if (st_cnt_q <= start_cycles) begin
      st_cnt_d = st_cnt_q + 1'b1;
    end
    if (!lm_run) begin
      lm_cnt_d = '0;
    end else if (lm_cnt_q <= lim_cycles) begin
      lm_cnt_d = lm_cnt_q + 1'b1;
    end
    start_flt = ce & st_run & (st_cnt_q == start_cycles);
    lim_flt   = ce & lm_run & (lm_cnt_q == lim_cycles);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_cnt_q <= '0;
      lm_cnt_q <= '0;
    end else if (ce) begin
      st_cnt_q <= st_cnt_d;
      lm_cnt_q <= lm_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_start_after_allow;
    @(posedge clk) disable iff (rst)
      start_flt |-> st_run && $past(st_run) && st_cnt_q == start_cycles;
  endproperty
  a_start_after_allow: assert property (p_start_after_allow)
    else $error("start-up fault before allowance elapsed");
endmodule

// ---- core/psefe_regs.sv ----
// Purpose: start-up/limit and supply event registers with clear-on-read twins
// Assumes: fault inputs are asynchronous levels from the port power stage
// Notes:   AXI4-Lite slave, one word per register, byte address = index * 4
`timescale 1ns/1ps
// Behaviour
// - start-up overcurrent past allowance: flag, port off
// - limit timeout switching port off sets flag
// - limit duration from 1Eh ports a/b, 1Fh c/d
// - 08h read-only, reading leaves it unchanged
// - 09h mirrors 08h, its read clears both
// - 0Ah bit 4 flags negative supply low
// - bit 5 flags logic supply low
// - bit 7 flags over-temperature, others reserved
// - 0Bh mirrors 0Ah, its read clears both
module psefe_regs
  import psefe_pkg::*;
#(
  parameter int STARTUP_TIME_US = 60000,
  parameter int LIM_STEP_US     = 1000,
  parameter int CNT_W           = 24
)(
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  input  wire logic               ce,
  input  wire psefe_fault_in_type fault_in,
  output logic [NPORT-1:0]        port_off_q,
  input  wire logic [AXI_AW-1:0]  s_awaddr,
  input  wire logic               s_awvalid,
  output logic                    s_awready,
  input  wire logic [31:0]        s_wdata,
  input  wire logic [3:0]         s_wstrb,
  input  wire logic               s_wvalid,
  output logic                    s_wready,
  output logic [1:0]              s_bresp,
  output logic                    s_bvalid,
  input  wire logic               s_bready,
  input  wire logic [AXI_AW-1:0]  s_araddr,
  input  wire logic               s_arvalid,
  output logic                    s_arready,
  output logic [31:0]             s_rdata,
  output logic [1:0]              s_rresp,
  output logic                    s_rvalid,
  input  wire logic               s_rready
);
  localparam int STARTUP_CYC  = STARTUP_TIME_US * CLK_MHZ;
  localparam int LIM_STEP_CYC = LIM_STEP_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  psefe_fault_in_type meta_q, sync_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce) begin
      meta_q <= fault_in;
      sync_q <= meta_q;
    end
  end

  // ----------------------------------------------------------------
  // per-port timers
  // ----------------------------------------------------------------
  logic [7:0]       lim_ab_q, lim_ab_d, lim_cd_q, lim_cd_d;
  logic [NPORT-1:0] st_flt, lm_flt;

  for (genvar n = 0; n < NPORT; n++) begin : g_port
    logic [LIM_FW-1:0] fld;
    logic [CNT_W-1:0]  lim_cyc;
    if (n < 2) begin : g_ab
      assign fld = lim_ab_q[n*LIM_FW +: LIM_FW];
    end else begin : g_cd
      assign fld = lim_cd_q[(n-2)*LIM_FW +: LIM_FW];
    end
    assign lim_cyc = CNT_W'((fld + 1) * LIM_STEP_CYC);
    psefe_port_timer #(.CNT_W(CNT_W)) psefe_port_timer_inst (
      .clk          (ref_clk),
      .rst          (sys_rst),
      .ce           (ce),
      .start_phase  (sync_q.startup_phase[n]),
      .over_start   (sync_q.over_startup[n]),
      .over_lim     (sync_q.over_limit[n]),
      .start_cycles (CNT_W'(STARTUP_CYC)),
      .lim_cycles   (lim_cyc),
      .start_flt    (st_flt[n]),
      .lim_flt      (lm_flt[n])
    );
  end

  // ----------------------------------------------------------------
  // bus slave and event registers
  // ----------------------------------------------------------------
  logic              aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [5:0]        aw_idx_q, aw_idx_d;
  logic [7:0]        wdat_q, wdat_d;
  logic              wen_q, wen_d;
  logic              awready_d, wready_d, arready_d, bvalid_d, rvalid_d;
  logic [1:0]        bresp_d, rresp_d;
  logic [31:0]       rdata_d;
  logic [7:0]        ev_sl_q, ev_sl_d, ev_su_q, ev_su_d;
  logic [7:0]        sl_set, su_set, sl_clr, su_clr;
  logic [NPORT-1:0]  port_off_d;
  logic              rd_take;
  logic [5:0]        ar_idx;

  always_comb begin
    ar_idx    = s_araddr[AXI_AW-1:ADDR_LSB];
    rd_take   = s_arvalid & s_arready;
    aw_have_d = aw_have_q;
    aw_idx_d  = aw_idx_q;
    w_have_d  = w_have_q;
    wdat_d    = wdat_q;
    wen_d     = wen_q;
    bvalid_d  = s_bvalid & ~s_bready;
    bresp_d   = s_bresp;
    rvalid_d  = s_rvalid & ~s_rready;
    rresp_d   = s_rresp;
    rdata_d   = s_rdata;
    lim_ab_d  = lim_ab_q;
    lim_cd_d  = lim_cd_q;
    sl_clr    = '0;
    su_clr    = '0;
    if (s_awvalid && s_awready) begin
      aw_have_d = 1'b1;
      aw_idx_d  = s_awaddr[AXI_AW-1:ADDR_LSB];
    end
    if (s_wvalid && s_wready) begin
      w_have_d = 1'b1;
      wdat_d   = s_wdata[7:0];
      wen_d    = s_wstrb[0];
    end
    if (aw_have_q && w_have_q && !s_bvalid) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OK;
      case (aw_idx_q)
        IDX_LIM_AB: if (wen_q) lim_ab_d = wdat_q;
        IDX_LIM_CD: if (wen_q) lim_cd_d = wdat_q;
        default:    bresp_d = RESP_ERR;
      endcase
    end
    if (rd_take) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OK;
      rdata_d  = '0;
      case (ar_idx)
        IDX_SL:     rdata_d[7:0] = ev_sl_q;
        IDX_SL_COR: begin
          rdata_d[7:0] = ev_sl_q;
          sl_clr       = 8'hff;
        end
        IDX_SU:     rdata_d[7:0] = ev_su_q;
        IDX_SU_COR: begin
          rdata_d[7:0] = ev_su_q;
          su_clr       = 8'hff;
        end
        IDX_LIM_AB: rdata_d[7:0] = lim_ab_q;
        IDX_LIM_CD: rdata_d[7:0] = lim_cd_q;
        default:    rresp_d = RESP_ERR;
      endcase
    end
    awready_d = ~aw_have_d & ~bvalid_d;
    wready_d  = ~w_have_d & ~bvalid_d;
    arready_d = ~rvalid_d;
    sl_set    = {lm_flt, st_flt};
    su_set    = '0;
    su_set[SU_NEG_BIT] = sync_q.neg_supply_low_flag;
    su_set[SU_LOG_BIT] = sync_q.logic_supply_low_flag;
    su_set[SU_TMP_BIT] = sync_q.over_temp;
    ev_sl_d   = (ev_sl_q & ~sl_clr) | sl_set;
    ev_su_d   = ((ev_su_q & ~su_clr) | su_set) & ~SU_RSV;
    port_off_d = st_flt | lm_flt;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_have_q  <= 1'b0;
      aw_idx_q   <= '0;
      w_have_q   <= 1'b0;
      wdat_q     <= '0;
      wen_q      <= 1'b0;
      s_awready  <= 1'b0;
      s_wready   <= 1'b0;
      s_arready  <= 1'b0;
      s_bvalid   <= 1'b0;
      s_bresp    <= RESP_OK;
      s_rvalid   <= 1'b0;
      s_rresp    <= RESP_OK;
      s_rdata    <= '0;
      lim_ab_q   <= LIM_RST;
      lim_cd_q   <= LIM_RST;
      ev_sl_q    <= EV_RST;
      ev_su_q    <= EV_RST;
      port_off_q <= '0;
    end else if (ce) begin
      aw_have_q  <= aw_have_d;
      aw_idx_q   <= aw_idx_d;
      w_have_q   <= w_have_d;
      wdat_q     <= wdat_d;
      wen_q      <= wen_d;
      s_awready  <= awready_d;
      s_wready   <= wready_d;
      s_arready  <= arready_d;
      s_bvalid   <= bvalid_d;
      s_bresp    <= bresp_d;
      s_rvalid   <= rvalid_d;
      s_rresp    <= rresp_d;
      s_rdata    <= rdata_d;
      lim_ab_q   <= lim_ab_d;
      lim_cd_q   <= lim_cd_d;
      ev_sl_q    <= ev_sl_d;
      ev_su_q    <= ev_su_d;
      port_off_q <= port_off_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_read_of(logic [5:0] idx);
    ce && rd_take && ar_idx == idx;
  endsequence

  property p_startup_flag;
    ce && |st_flt |=> (ev_sl_q[3:0] & $past(st_flt)) == $past(st_flt)
      && (port_off_q & $past(st_flt)) == $past(st_flt);
  endproperty
  a_startup_flag: assert property (p_startup_flag)
    else $error("start-up fault not flagged or port not switched off");

  property p_limit_flag;
    ce && |lm_flt |=> (ev_sl_q[7:4] & $past(lm_flt)) == $past(lm_flt);
  endproperty
  a_limit_flag: assert property (p_limit_flag)
    else $error("limit fault not flagged");

  property p_ro_read_keeps;
    s_read_of(IDX_SL) |=> ev_sl_q == ($past(ev_sl_q) | $past(sl_set));
  endproperty
  a_ro_read_keeps: assert property (p_ro_read_keeps)
    else $error("read of plain event register changed it");

  property p_sl_cor;
    s_read_of(IDX_SL_COR) |=> s_rvalid && s_rdata[7:0] == $past(ev_sl_q)
      && ev_sl_q == $past(sl_set);
  endproperty
  a_sl_cor: assert property (p_sl_cor)
    else $error("clear-on-read twin wrong data or no clear");

  property p_neg_low;
    ce && sync_q.neg_supply_low_flag |=> ev_su_q[SU_NEG_BIT];
  endproperty
  a_neg_low: assert property (p_neg_low)
    else $error("negative supply low not flagged");

  property p_logic_low;
    ce && sync_q.logic_supply_low_flag |=> ev_su_q[SU_LOG_BIT];
  endproperty
  a_logic_low: assert property (p_logic_low)
    else $error("logic supply low not flagged");

  property p_temp_rsv;
    (ce && sync_q.over_temp |=> ev_su_q[SU_TMP_BIT]) and
      (1'b1 |-> (ev_su_q & SU_RSV) == 8'h00);
  endproperty
  a_temp_rsv: assert property (p_temp_rsv)
    else $error("over-temperature missing or reserved bit set");

  property p_su_cor;
    s_read_of(IDX_SU_COR) |=> s_rdata[7:0] == $past(ev_su_q)
      && ev_su_q == ($past(su_set) & ~SU_RSV);
  endproperty
  a_su_cor: assert property (p_su_cor)
    else $error("supply clear-on-read twin wrong");

  property p_sticky;
    ce && !(rd_take && ar_idx == IDX_SL_COR)
      |=> (ev_sl_q & $past(ev_sl_q)) == $past(ev_sl_q);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("event bit dropped without clearing read");
endmodule

// ---- sim/psefe_stage_model.sv ----
// Purpose: behavioural port power stage driving the fault inputs
// Assumes: bench asks for overcurrent episodes per port and three supply alarms shared by all ports
// Notes:   an episode stops drawing current once the block turns the port off
`timescale 1ns/1ps
module psefe_stage_model
  import psefe_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic [NPORT-1:0] port_off_q,
  input  wire logic [NPORT-1:0] start_req,
  input  wire logic [NPORT-1:0] lim_req,
  input  wire logic [2:0]       supply_low,
  output psefe_fault_in_type    fault_in
);
  logic [NPORT-1:0] tripped_q;
  logic [NPORT-1:0] tripped_d;

  // a tripped port stays dark until the bench ends the episode
  always_comb begin
    tripped_d = (tripped_q | port_off_q) & (start_req | lim_req);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tripped_q <= '0;
    end else begin
      tripped_q <= tripped_d;
    end
  end

  always_comb begin
    fault_in.startup_phase         = start_req;
    fault_in.over_startup          = start_req & ~tripped_q & ~port_off_q;
    fault_in.over_limit            = lim_req & ~tripped_q & ~port_off_q;
    fault_in.neg_supply_low_flag   = supply_low[0];
    fault_in.logic_supply_low_flag = supply_low[1];
    fault_in.over_temp             = supply_low[2];
  end
endmodule

// ---- sim/psefe_regs_tb.sv ----
// Purpose: self-checking bench for the fault and supply event registers
// Assumes: timing parameters shortened to one microsecond steps
// Notes:   expected reads and responses queue up, a monitor compares them
`timescale 1ns/1ps
module psefe_regs_tb
  import psefe_pkg::*;
;
  localparam int CYC = CLK_MHZ;
  logic               ref_clk   = 1'b0;
  logic               sys_rst   = 1'b1;
  logic               ce        = 1'b1;
  logic [NPORT-1:0]   start_req = '0;
  logic [NPORT-1:0]   lim_req   = '0;
  logic [2:0]         supply_low = '0;
  logic [NPORT-1:0]   port_off_q;
  psefe_fault_in_type fault_in;
  logic [AXI_AW-1:0]  s_awaddr  = '0;
  logic [AXI_AW-1:0]  s_araddr  = '0;
  logic [31:0]        s_wdata   = '0;
  logic [3:0]         s_wstrb   = '0;
  logic               s_awvalid = 1'b0;
  logic               s_wvalid  = 1'b0;
  logic               s_bready  = 1'b0;
  logic               s_arvalid = 1'b0;
  logic               s_rready  = 1'b0;
  logic               s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]         s_bresp, s_rresp;
  logic [31:0]        s_rdata;
  logic [33:0]        rd_q[$];
  logic [1:0]         b_q[$];
  logic [7:0]         lim_ab, lim_cd, fld;
  int                 miscompares = 0;
  int                 tests_run   = 0;
  int                 seed        = 32'h3066;

  always #20 ref_clk = ~ref_clk;

  psefe_stage_model psefe_stage_model_inst (.ref_clk, .sys_rst, .port_off_q, .start_req,
    .lim_req, .supply_low, .fault_in);

  psefe_regs #(.STARTUP_TIME_US(1), .LIM_STEP_US(1)) psefe_regs_inst (.ref_clk, .sys_rst,
    .ce(ce), .fault_in, .port_off_q, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready);

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic chk_bus(input string nm, input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_evt(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (s_rvalid === 1'b1 && s_rready === 1'b1) begin
      chk_bus("read", rd_q.pop_front(), {s_rresp, s_rdata});
    end
    if (s_bvalid === 1'b1 && s_bready === 1'b1) begin
      chk_bus("bresp", {32'h0, b_q.pop_front()}, {32'h0, s_bresp});
    end
  end

  // ----------------------------------------------------------------
  // bus master and fault helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
                    input logic [1:0] r);
    b_q.push_back(r);
    @(posedge ref_clk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_wstrb   <= st;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
    rd_q.push_back({r, 24'h0, e});
    @(posedge ref_clk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    s_rready <= 1'b0;
  endtask

  // counts edges from the request until the turn-off pulse
  task automatic wait_off(input int p, input int lo);
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (port_off_q[p] !== 1'b1 && k < lo + 40);
    chk_evt("turn-off delay", 1'b1, k >= lo && k <= lo + 6);
    @(posedge ref_clk);
    chk_evt("turn-off pulse", 1'b0, port_off_q[p]);
    start_req <= '0;
    lim_req   <= '0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      rd(8'h20 + 8'(4 * i), EV_RST, RESP_OK);
    end
    rd(8'h00, 8'h00, RESP_ERR);
    wr(8'h20, 32'hff, 4'hf, RESP_ERR);
    rd(8'h20, 8'h00, RESP_OK);
    lim_ab = 8'($random(seed));
    lim_cd = 8'($random(seed));
    wr(8'h78, {24'h0, lim_ab}, 4'hf, RESP_OK);
    wr(8'h7c, 32'($random(seed)), 4'he, RESP_OK);
    wr(8'h7c, {24'h0, lim_cd}, 4'h1, RESP_OK);
    rd(8'h78, lim_ab, RESP_OK);
    rd(8'h7c, lim_cd, RESP_OK);
    for (int p = 0; p < NPORT; p++) begin
      start_req[p] <= 1'b1;
      wait_off(p, CYC);
      rd(8'h20, 8'h01 << p, RESP_OK);
      rd(8'h20, 8'h01 << p, RESP_OK);
      rd(8'h24, 8'h01 << p, RESP_OK);
      rd(8'h20, 8'h00, RESP_OK);
    end
    for (int p = 0; p < NPORT; p++) begin
      fld = ((p < 2) ? lim_ab : lim_cd) >> (4 * (p % 2));
      lim_req[p] <= 1'b1;
      wait_off(p, (int'(fld[3:0]) + 1) * CYC);
      rd(8'h24, 8'h10 << p, RESP_OK);
      rd(8'h20, 8'h00, RESP_OK);
    end
    // an alarm that comes and goes while ce is low must leave no trace
    ce         <= 1'b0;
    supply_low <= 3'b100;
    repeat (6) @(posedge ref_clk);
    supply_low <= 3'b000;
    repeat (2) @(posedge ref_clk);
    ce         <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(8'h28, 8'h00, RESP_OK);
    supply_low <= 3'b001;
    repeat (4) @(posedge ref_clk);
    rd(8'h28, 8'h10, RESP_OK);
    supply_low <= 3'b111;
    repeat (4) @(posedge ref_clk);
    // host reads the 0Bh twin here while all three alarms persist, so the cleared bits set again
    rd(8'h2c, 8'hb0, RESP_OK);
    rd(8'h28, 8'hb0, RESP_OK);
    supply_low <= 3'b000;
    repeat (4) @(posedge ref_clk);
    rd(8'h2c, 8'hb0, RESP_OK);
    rd(8'h28, 8'h00, RESP_OK);
    // let the monitor take the last answer before the verdict
    repeat (2) @(posedge ref_clk);
    chk_bus("pending answers", 34'h0, 34'(rd_q.size() + b_q.size()));
    summarize();
  end

  initial begin
    #(40 * 20000);
    miscompares++;
    summarize();
  end
endmodule
